// ==== sid_cfg.svh ====
// Field positions, register map and reset values of the source-1 indirect decoder
`ifndef SID_CFG_SVH
`define SID_CFG_SVH

// ****************************************
// Instruction field positions
// ****************************************
`define SID_RSV_MSB   31
`define SID_RSV_LSB   25
`define SID_VS_MSB    24
`define SID_VS_LSB    21
`define SID_RSV20     20
`define SID_CS_MSB    19
`define SID_CS_LSB    16
`define SID_AM_BIT    15
`define SID_SM_MSB    14
`define SID_SM_LSB    13
`define SID_AS_MSB    12
`define SID_AS_LSB    10
`define SID_AI16_MSB  9
`define SID_AI16_LSB  4
`define SID_CE_MSB    3
`define SID_CE_LSB    0
`define SID_W_MSB     20
`define SID_W_LSB     18
`define SID_HS_MSB    17
`define SID_HS_LSB    16
`define SID_AI1_MSB   9
`define SID_AI1_LSB   0

// ****************************************
// Register map
// ****************************************
`define SID_REG_CTRL   8'h00
`define SID_REG_STATUS 8'h04
`define SID_REG_LASTDW 8'h08
`define SID_REG_COUNT  8'h0C
`define SID_REG_FIELDS 8'h10
`define SID_CTRL_RST   2'h3
`define SID_CTRL_EN    0
`define SID_CTRL_CHK   1
`define SID_STAT_RSV   0
`define SID_STAT_IMM   1

`endif

// ==== sid_decoder.sv ====
// Source-1 indirect doubleword decoder with Wishbone control registers
`timescale 1ns/1ps
`include "sid_cfg.svh"

module sid_decoder
    import sid_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Fetch side
    input  wire logic        dw_valid_i,
    input  wire logic [31:0] dw_i,
    input  wire logic        four_component_alignment_i,
    input  wire logic        second_source_operand_immediate_i,
    input  wire logic        src0_immediate_i,
    // Operand fetch side
    output logic             valid_o,
    output logic             is_immediate_o,
    output logic [31:0]      immediate_word_o,
    output sid_layout_t      layout_o,
    output logic [3:0]       vertical_stride_o,
    output logic [3:0]       channel_swizzle_select_hi_o,
    output logic             operand_address_mode_o,
    output logic [1:0]       source_modifier_o,
    output logic [2:0]       address_register_subindex_o,
    output logic [9:0]       address_offset_immediate_o,
    output logic [3:0]       component_enable_mask_o,
    output logic [2:0]       region_width_o,
    output logic [1:0]       horizontal_stride_o,
    output logic             reserved_violation_o,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o
);

    // ****************************************
    // Helpers
    // ****************************************
    // Right-aligned field between two bit positions
    function automatic logic [31:0] fld(
        input logic [31:0] dw,
        input int          msb,
        input int          lsb
    );
        logic [31:0] mask;
        mask = (32'h1 << (msb - lsb + 1)) - 32'h1;
        fld  = (dw >> lsb) & mask;
    endfunction : fld

    // Register offset match
    function automatic logic reg_hit(
        input logic [7:0] adr,
        input logic [7:0] offset
    );
        reg_hit = (adr == offset);
    endfunction : reg_hit

    // ****************************************
    // State
    // ****************************************
    logic              decode_en;
    logic              check_en;
    logic              sticky_rsv;
    logic              sticky_imm;
    logic [31:0]       last_dw;
    logic [CNT_W-1:0]  decode_count;

    logic              next_valid;
    logic              next_is_imm;
    logic [31:0]       next_imm_word;
    sid_layout_t       next_layout;
    logic [3:0]        next_vs;
    logic [3:0]        next_cs;
    logic              next_am;
    logic [1:0]        next_sm;
    logic [2:0]        next_as;
    logic [9:0]        next_ai;
    logic [3:0]        next_ce;
    logic [2:0]        next_w;
    logic [1:0]        next_hs;
    logic              next_rsv;
    logic [31:0]       next_last_dw;
    logic [CNT_W-1:0]  next_count;
    logic              rsv_event;
    logic              imm_event;

    logic              next_decode_en;
    logic              next_check_en;
    logic              next_sticky_rsv;
    logic              next_sticky_imm;
    logic              next_ack;
    logic [31:0]       next_dat;
    logic              bus_req;
    logic              bus_wr;

    // ****************************************
    // Decode path
    // ****************************************
    always_comb begin
        next_valid    = 1'b0;
        next_is_imm   = 1'b0;
        next_imm_word = 32'h0000_0000;
        next_layout   = SID_LAYOUT_NONE;
        next_vs       = 4'h0;
        next_cs       = 4'h0;
        next_am       = 1'b0;
        next_sm       = 2'h0;
        next_as       = 3'h0;
        next_ai       = 10'h000;
        next_ce       = 4'h0;
        next_w        = 3'h0;
        next_hs       = 2'h0;
        next_rsv      = 1'b0;
        next_last_dw  = last_dw;
        next_count    = decode_count;
        rsv_event     = 1'b0;
        imm_event     = 1'b0;
        if (dw_valid_i && decode_en) begin
            next_valid   = 1'b1;
            next_last_dw = dw_i;
            // Wrapping count of accepted words
            next_count   = decode_count + {{(CNT_W-1){1'b0}}, 1'b1};
            // Either immediate source takes over the whole word
            if (second_source_operand_immediate_i || src0_immediate_i) begin
                next_is_imm   = 1'b1;
                next_imm_word = dw_i;
                imm_event     = 1'b1;
            end else begin
                next_vs = 4'(fld(dw_i, `SID_VS_MSB, `SID_VS_LSB));
                next_am = dw_i[`SID_AM_BIT];
                next_sm = 2'(fld(dw_i, `SID_SM_MSB, `SID_SM_LSB));
                next_as = 3'(fld(dw_i, `SID_AS_MSB, `SID_AS_LSB));
                if (four_component_alignment_i) begin
                    next_layout = SID_LAYOUT_FOUR;
                    next_cs = 4'(fld(dw_i, `SID_CS_MSB, `SID_CS_LSB));
                    next_ai = {6'(fld(dw_i, `SID_AI16_MSB, `SID_AI16_LSB)), 4'h0};
                    next_ce = 4'(fld(dw_i, `SID_CE_MSB, `SID_CE_LSB));
                end else begin
                    next_layout = SID_LAYOUT_SCALAR;
                    next_w  = 3'(fld(dw_i, `SID_W_MSB, `SID_W_LSB));
                    next_hs = 2'(fld(dw_i, `SID_HS_MSB, `SID_HS_LSB));
                    next_ai = 10'(fld(dw_i, `SID_AI1_MSB, `SID_AI1_LSB));
                end
                // Reserved bits checked for register operands only
                // flag nonzero reserved bits
                if (check_en) begin
                    if (fld(dw_i, `SID_RSV_MSB, `SID_RSV_LSB) != 32'h0000_0000) begin
                        next_rsv = 1'b1;
                    end else if (four_component_alignment_i && dw_i[`SID_RSV20]) begin
                        next_rsv = 1'b1;
                    end
                end
                // Feeds the sticky status flag
                rsv_event = next_rsv;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            valid_o                     <= 1'b0;
            is_immediate_o              <= 1'b0;
            immediate_word_o            <= 32'h0000_0000;
            layout_o                    <= SID_LAYOUT_NONE;
            vertical_stride_o           <= 4'h0;
            channel_swizzle_select_hi_o <= 4'h0;
            operand_address_mode_o      <= 1'b0;
            source_modifier_o           <= 2'h0;
            address_register_subindex_o <= 3'h0;
            address_offset_immediate_o  <= 10'h000;
            component_enable_mask_o     <= 4'h0;
            region_width_o              <= 3'h0;
            horizontal_stride_o         <= 2'h0;
            reserved_violation_o        <= 1'b0;
            last_dw                     <= 32'h0000_0000;
            decode_count                <= '0;
        end else begin
            valid_o                     <= next_valid;
            is_immediate_o              <= next_is_imm;
            immediate_word_o            <= next_imm_word;
            layout_o                    <= next_layout;
            vertical_stride_o           <= next_vs;
            channel_swizzle_select_hi_o <= next_cs;
            operand_address_mode_o      <= next_am;
            source_modifier_o           <= next_sm;
            address_register_subindex_o <= next_as;
            address_offset_immediate_o  <= next_ai;
            component_enable_mask_o     <= next_ce;
            region_width_o              <= next_w;
            horizontal_stride_o         <= next_hs;
            reserved_violation_o        <= next_rsv;
            last_dw                     <= next_last_dw;
            decode_count                <= next_count;
        end
    end

    // ****************************************
    // Wishbone response: acknowledge and read data
    // ****************************************
    always_comb begin
        bus_req  = wb_cyc_i && wb_stb_i;
        // One-cycle ack, dropped even if the strobe stays up
        next_ack = bus_req && !wb_ack_o;
        next_dat = 32'h0000_0000;
        if (bus_req && !wb_ack_o && !wb_we_i) begin
            if (reg_hit(wb_adr_i, `SID_REG_CTRL)) begin
                next_dat[`SID_CTRL_EN]  = decode_en;
                next_dat[`SID_CTRL_CHK] = check_en;
            end else if (reg_hit(wb_adr_i, `SID_REG_STATUS)) begin
                next_dat[`SID_STAT_RSV] = sticky_rsv;
                next_dat[`SID_STAT_IMM] = sticky_imm;
            end else if (reg_hit(wb_adr_i, `SID_REG_LASTDW)) begin
                next_dat = last_dw;
            end else if (reg_hit(wb_adr_i, `SID_REG_COUNT)) begin
                next_dat[CNT_W-1:0] = decode_count;
            end else if (reg_hit(wb_adr_i, `SID_REG_FIELDS)) begin
                next_dat = {vertical_stride_o, channel_swizzle_select_hi_o,
                            operand_address_mode_o, source_modifier_o,
                            address_register_subindex_o,
                            address_offset_immediate_o,
                            component_enable_mask_o, 4'h0};
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= next_ack;
            wb_dat_o <= next_dat;
        end
    end

    // ****************************************
    // Control register and sticky status
    // ****************************************
    always_comb begin
        // Writes land on the edge that samples ack high
        bus_wr          = bus_req && wb_we_i && wb_ack_o;
        next_decode_en  = decode_en;
        next_check_en   = check_en;
        next_sticky_rsv = sticky_rsv;
        next_sticky_imm = sticky_imm;
        if (bus_wr && wb_sel_i[0]) begin
            if (reg_hit(wb_adr_i, `SID_REG_CTRL)) begin
                next_decode_en = wb_dat_i[`SID_CTRL_EN];
                next_check_en  = wb_dat_i[`SID_CTRL_CHK];
            end else if (reg_hit(wb_adr_i, `SID_REG_STATUS)) begin
                if (wb_dat_i[`SID_STAT_RSV]) begin
                    next_sticky_rsv = 1'b0;
                end
                if (wb_dat_i[`SID_STAT_IMM]) begin
                    next_sticky_imm = 1'b0;
                end
            end
        end
        // Set beats clear in the same cycle
        if (rsv_event) begin
            next_sticky_rsv = 1'b1;
        end
        if (imm_event) begin
            next_sticky_imm = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            decode_en  <= 1'(`SID_CTRL_RST >> `SID_CTRL_EN);
            check_en   <= 1'(`SID_CTRL_RST >> `SID_CTRL_CHK);
            sticky_rsv <= 1'b0;
            sticky_imm <= 1'b0;
        end else begin
            decode_en  <= next_decode_en;
            check_en   <= next_check_en;
            sticky_rsv <= next_sticky_rsv;
            sticky_imm <= next_sticky_imm;
        end
    end

endmodule : sid_decoder

// ==== sid_decoder_chk_asserts.sv ====
// Port-level assertions for the source-1 indirect decoder
`timescale 1ns/1ps
module sid_decoder_chk
    import sid_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic [31:0] dw_i,
    input wire logic        four_component_alignment_i,
    input wire logic        second_source_operand_immediate_i,
    input wire logic        src0_immediate_i,
    input wire logic        valid_o,
    input wire logic        is_immediate_o,
    input wire logic [31:0] immediate_word_o,
    input wire sid_layout_t layout_o,
    input wire logic [3:0]  vertical_stride_o,
    input wire logic [3:0]  channel_swizzle_select_hi_o,
    input wire logic        operand_address_mode_o,
    input wire logic [1:0]  source_modifier_o,
    input wire logic [2:0]  address_register_subindex_o,
    input wire logic [9:0]  address_offset_immediate_o,
    input wire logic [3:0]  component_enable_mask_o,
    input wire logic [2:0]  region_width_o,
    input wire logic [1:0]  horizontal_stride_o,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ****************************************
    // Decoded word kinds
    // ****************************************
    sequence reg_s;
        valid_o && !is_immediate_o;
    endsequence
    sequence four_s;
        valid_o && layout_o == SID_LAYOUT_FOUR;
    endsequence
    sequence scal_s;
        valid_o && layout_o == SID_LAYOUT_SCALAR;
    endsequence
    // ****************************************
    // Field extraction and ack timing
    // ****************************************
    AST_LAYOUT: assert property (
        reg_s |-> layout_o == ($past(four_component_alignment_i) ? SID_LAYOUT_FOUR
                                                                 : SID_LAYOUT_SCALAR))
        else $error("layout mismatch");
    AST_VSTRIDE: assert property (
        reg_s |-> vertical_stride_o == $past(dw_i[24:21])) else $error("stride mismatch");
    AST_FOUR: assert property (
        four_s |-> channel_swizzle_select_hi_o == $past(dw_i[19:16])
            && address_offset_immediate_o == {$past(dw_i[9:4]), 4'h0}
            && component_enable_mask_o == $past(dw_i[3:0])) else $error("four layout fields");
    AST_ADDR: assert property (
        reg_s |-> {operand_address_mode_o, source_modifier_o, address_register_subindex_o}
            == $past(dw_i[15:10])) else $error("address fields mismatch");
    AST_SCALAR: assert property (
        scal_s |-> region_width_o == $past(dw_i[20:18])
            && horizontal_stride_o == $past(dw_i[17:16])
            && address_offset_immediate_o == $past(dw_i[9:0])) else $error("scalar fields");
    AST_IMMZERO: assert property (
        valid_o && is_immediate_o |-> layout_o == SID_LAYOUT_NONE
            && {vertical_stride_o, channel_swizzle_select_hi_o, operand_address_mode_o,
                source_modifier_o, address_register_subindex_o, address_offset_immediate_o,
                component_enable_mask_o, region_width_o, horizontal_stride_o} == 33'h0)
        else $error("immediate fields not zero");
    AST_IMMWORD: assert property (
        valid_o |-> is_immediate_o == ($past(second_source_operand_immediate_i) || $past(src0_immediate_i))
            && (!is_immediate_o || immediate_word_o == $past(dw_i))) else $error("immediate");
    AST_ACK: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o) else $error("ack timing");
endmodule : sid_decoder_chk

bind sid_decoder sid_decoder_chk u_chk (.*);

// ==== sid_fetch_model.sv ====
// Fetch-stage model feeding source-1 doublewords with random gaps
`timescale 1ns/1ps
module sid_fetch_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        run_i,
    input  wire logic        rsv_i,
    output logic             dw_valid_o,
    output logic [31:0]      dw_o,
    output logic             four_o,
    output logic             s1_imm_o,
    output logic             s0_imm_o
);
    logic [31:0] w;
    logic        f;
    always @(posedge clk_i) begin
        w = $urandom;
        f = 1'($urandom_range(1));
        if (!rsv_i) begin
            w[31:25] = 7'h00;
            w[20] = w[20] & ~f;
        end
        dw_valid_o <= !rst_i && run_i && $urandom_range(3) != 0;
        dw_o       <= w;
        four_o     <= f;
        s1_imm_o   <= $urandom_range(7) == 0;
        s0_imm_o   <= $urandom_range(7) == 0;
    end
endmodule : sid_fetch_model

// ==== sid_pkg.sv ====
// Types shared by the source-1 indirect decoder
package sid_pkg;

    // ****************************************
    // Layout selection, one-hot except SID_LAYOUT_NONE, which is all zero
    // ****************************************
    typedef enum logic [1:0] {
        SID_LAYOUT_NONE   = 2'b00,
        SID_LAYOUT_FOUR   = 2'b01,
        SID_LAYOUT_SCALAR = 2'b10
    } sid_layout_t;

endpackage : sid_pkg

// ==== tb.sv ====
// Self-checking bench for the source-1 indirect decoder
`timescale 1ns/1ps
module tb;
    import sid_pkg::*;
    logic        clk_i = 1'b0, rst_i = 1'b1, run = 1'b0, rsv = 1'b0;
    logic        dw_valid_i, four_component_alignment_i, second_source_operand_immediate_i, src0_immediate_i;
    logic [31:0] dw_i, immediate_word_o, wb_dat_o, wb_dat_i = '0, last_dw = '0;
    logic        valid_o, is_immediate_o, operand_address_mode_o, reserved_violation_o;
    sid_layout_t layout_o;
    logic [3:0]  vertical_stride_o, channel_swizzle_select_hi_o, component_enable_mask_o;
    logic [1:0]  source_modifier_o, horizontal_stride_o, ctrl = 2'h3, stat = 2'h0;
    logic [2:0]  address_register_subindex_o, region_width_o;
    logic [9:0]  address_offset_immediate_o;
    logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
    logic [7:0]  wb_adr_i = '0;
    logic [3:0]  wb_sel_i = 4'hF;
    logic [15:0] n_dec = '0;
    logic [68:0] exp_q[$];
    logic [68:0] e, exp_n;
    int          err_total = 0, comparisons = 0;
    wire logic [68:0] act = {is_immediate_o, immediate_word_o, layout_o, vertical_stride_o,
        channel_swizzle_select_hi_o, operand_address_mode_o, source_modifier_o,
        address_register_subindex_o, address_offset_immediate_o, component_enable_mask_o,
        region_width_o, horizontal_stride_o, reserved_violation_o};

    sid_decoder dut (.*);
    sid_fetch_model u_fetch (.clk_i(clk_i), .rst_i(rst_i), .run_i(run), .rsv_i(rsv),
        .dw_valid_o(dw_valid_i), .dw_o(dw_i), .four_o(four_component_alignment_i),
        .s1_imm_o(second_source_operand_immediate_i), .s0_imm_o(src0_immediate_i));

    always #4 clk_i = ~clk_i;

    task automatic fail(input string m);
        err_total++;
        $display("[ERR] %0t %s", $time, m);
    endtask : fail
    task automatic chk_dec(input logic [68:0] a, input logic [68:0] x);
        comparisons++;
        if (a !== x) fail("decoded fields mismatch");
    endtask : chk_dec
    task automatic chk_reg(input logic [31:0] a, input logic [31:0] x);
        comparisons++;
        if (a !== x) fail("register read mismatch");
    endtask : chk_reg
    function automatic logic [68:0] expect_f(input logic [31:0] d, input logic f, imm, chk);
        if (imm) return {1'b1, d, 36'h0};
        if (f) return {33'h0, SID_LAYOUT_FOUR, d[24:21], d[19:16], d[15:10], d[9:4], 4'h0,
                       d[3:0], 5'h00, chk & (|d[31:25] | d[20])};
        return {33'h0, SID_LAYOUT_SCALAR, d[24:21], 4'h0, d[15:10], d[9:0], 4'h0, d[20:16],
                chk & (|d[31:25])};
    endfunction : expect_f
    task automatic end_sim;
        if (exp_q.size() != 0) fail("results missing");
        if (err_total == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : end_sim
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, x);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        if (!w) chk_reg(wb_dat_o, x);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask : wb
    task automatic run_phase(input logic r);
        rsv <= r;
        run <= 1'b1;
        repeat (300) @(posedge clk_i);
        run <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask : run_phase

    // ****************************************
    // Result monitor
    // ****************************************
    always @(posedge clk_i) begin
        if (!rst_i && valid_o === 1'b1) begin
            exp_n = 69'h0;
            if (exp_q.size() == 0) fail("unexpected result");
            else exp_n = exp_q.pop_front();
            chk_dec(69'(act[68:34]), 69'(exp_n[68:34]));
            chk_dec(69'(act[33:20]), 69'(exp_n[33:20]));
            chk_dec(69'(act[19:0]), 69'(exp_n[19:0]));
        end else if (!rst_i) chk_dec(act, 69'h0);
    end

    // ****************************************
    // Expectation notes
    // ****************************************
    always @(posedge clk_i) begin
        if (!rst_i && dw_valid_i === 1'b1 && ctrl[0]) begin
            e = expect_f(dw_i, four_component_alignment_i,
                         second_source_operand_immediate_i | src0_immediate_i, ctrl[1]);
            exp_q.push_back(e);
            stat = stat | {e[68], e[0]};
            last_dw = dw_i;
            n_dec++;
        end
    end

    initial begin
        repeat (5000) @(posedge clk_i);
        fail("timeout");
        end_sim;
    end

    initial begin
        void'($urandom(58));
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb(1'b0, 8'h00, '0, 32'h3);
        wb(1'b0, 8'h04, '0, '0);
        wb(1'b1, 8'hFC, 32'hFFFFFFFF, '0);
        wb(1'b0, 8'hFC, '0, '0);
        run_phase(1'b0);
        run_phase(1'b1);
        wb(1'b1, 8'h00, 32'h1, '0);
        ctrl = 2'h1;
        run_phase(1'b1);
        wb(1'b1, 8'h00, 32'h0, '0);
        ctrl = 2'h0;
        run_phase(1'b0);
        wb(1'b1, 8'h00, 32'h3, '0);
        ctrl = 2'h3;
        wb(1'b0, 8'h04, '0, {30'h0, stat});
        wb(1'b0, 8'h08, '0, last_dw);
        wb(1'b0, 8'h0C, '0, {16'h0, n_dec});
        wb(1'b1, 8'h04, 32'h3, '0);
        wb(1'b0, 8'h04, '0, '0);
        wb(1'b0, 8'h10, '0, '0);
        wb_sel_i <= 4'hE;
        wb(1'b1, 8'h00, 32'h0, '0);
        wb_sel_i <= 4'hF;
        wb(1'b0, 8'h00, '0, {30'h0, ctrl});
        end_sim;
    end
endmodule : tb
